/* File: core/htr_top.sv */
// harvester thermal-zone configuration register bank and decode
//
// Contract
// - With the inhibit control bit at 0 and the inhibit conditions met, the harvester-off output is asserted and the switch follows the switch-mode field.
// - With the inhibit control bit at 1 and the inhibit conditions met, the harvester-off output stays low and the switch is forced to ideal diode.
// - The inhibit conditions are no charger input, interaction enabled, monitor selection not 00, and a zone that inhibits harvesting.
// - With interaction enabled and a charger input present, the harvester-off output is held asserted.
// - In the warm zone the threshold is the base lowered by 150, 100, 50 or 0 mV per its two-bit field.
// - In the room zone the threshold is the base lowered by 150, 100, 50 or 0 mV per its two-bit field.
// - In the cool zone the threshold is the base lowered by 150, 100, 50 or 0 mV per its two-bit field.
// - The switch-mode field gives direct path for 00, threshold-dependent for 01, ideal diode for 10, and 11 is reserved.
// - The base threshold is 4.05 V plus 50 mV per code step, with codes 1100 to 1111 reserved.
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ps
`include "htr_cfg.svh"

module htr_top (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic i_charger_input,
  input wire logic i_zone_inhibit,
  input wire logic [2:0] i_zone,
  output logic [7:0] o_rdata,
  output logic o_harvester_off_output,
  output logic [1:0] o_fet_mode,
  output logic [12:0] o_thresh_mv
);

  htr_pkg::htr_state_t st;
  htr_pkg::htr_state_t next_st;
  htr_pkg::htr_bus_req_t req;

  logic [1:0] switch_mode;
  logic [3:0] base_regulation_threshold;
  logic thermal_inhibit_ctl;
  logic harvest_interact_en;
  logic [1:0] harvest_thermal_monitor_sel;
  logic inhibit_cond;
  logic [12:0] thresh_mv;

  // decode of the switch-mode field into the switch operating mode
  function automatic htr_pkg::htr_fet_t switch_decode(input logic [1:0] code);
    unique case (code)
      2'h0: switch_decode = htr_pkg::HTR_FET_DIRECT;
      2'h1: switch_decode = htr_pkg::HTR_FET_AUTO;
      2'h2: switch_decode = htr_pkg::HTR_FET_IDEAL;
      // reserved code falls back to the safe diode mode
      default: switch_decode = htr_pkg::HTR_FET_IDEAL;
    endcase
  endfunction

  // read mux for the register map
  function automatic logic [7:0] read_reg(input logic [7:0] addr,
                                          input htr_pkg::htr_state_t s);
    unique case (addr)
      `HTR_OFF_HARVEST_CONFIG: read_reg = s.harvest_config;
      `HTR_OFF_THERMAL_CONFIG: read_reg = {1'b0, s.thermal_config};
      `HTR_OFF_HARVEST_CTRL: read_reg = {5'h00, s.harvest_ctrl};
      `HTR_OFF_STATUS: read_reg = {s.fet, s.harvester_off, s.chg_s2, s.inh_s2, s.zone};
      `HTR_OFF_THRESH_LO: read_reg = s.thresh[7:0];
      `HTR_OFF_THRESH_HI: read_reg = {3'h0, s.thresh[12:8]};
      default: read_reg = 8'h00;
    endcase
  endfunction

  always_comb begin
    req.addr = i_addr;
    req.wdata = i_wdata;
    req.wr = i_wr;
    req.rd = i_rd;
  end

  always_comb begin
    switch_mode = st.harvest_config[`HTR_SWITCH_MODE_HI:`HTR_SWITCH_MODE_LO];
    base_regulation_threshold = st.harvest_config[`HTR_BASE_HI:`HTR_BASE_LO];
    thermal_inhibit_ctl = st.thermal_config[`HTR_INHIBIT_CTL_BIT];
    harvest_interact_en = st.harvest_ctrl[`HTR_INTERACT_EN_BIT];
    harvest_thermal_monitor_sel = st.harvest_ctrl[`HTR_MON_SEL_HI:`HTR_MON_SEL_LO];
    inhibit_cond = !st.chg_s2 && harvest_interact_en &&
                   (harvest_thermal_monitor_sel != `HTR_MON_SEL_OFF) && st.inh_s2;
  end

  htr_thresh u_thresh (
    .i_base_code(base_regulation_threshold),
    .i_thermal_config(st.thermal_config),
    .i_zone(st.zone),
    .o_thresh_mv(thresh_mv),
    .o_base_reserved()
  );

  always_comb begin
    next_st = st;
    // pins pass two flip-flops before use
    next_st.chg_s1 = i_charger_input;
    next_st.chg_s2 = st.chg_s1;
    next_st.inh_s1 = i_zone_inhibit;
    next_st.inh_s2 = st.inh_s1;
    next_st.zone_s1 = i_zone;
    next_st.zone_s2 = st.zone_s1;
    next_st.zone_prev = st.zone_s2;
    // zone code taken only once stable for two samples, so a skewed bit never shows
    if (st.zone_s2 == st.zone_prev) begin
      next_st.zone = st.zone_prev;
    end
    if (req.wr) begin
      unique case (req.addr)
        `HTR_OFF_HARVEST_CONFIG: next_st.harvest_config = req.wdata;
        `HTR_OFF_THERMAL_CONFIG: next_st.thermal_config = req.wdata[6:0];
        `HTR_OFF_HARVEST_CTRL: next_st.harvest_ctrl = req.wdata[2:0];
        default: next_st.harvest_config = st.harvest_config;
      endcase
    end
    next_st.rdata = req.rd ? read_reg(req.addr, st) : 8'h00;
    // harvester shutoff output
    if (harvest_interact_en && st.chg_s2) begin
      next_st.harvester_off = 1'b1;
    end else if (inhibit_cond) begin
      next_st.harvester_off = !thermal_inhibit_ctl;
    end else begin
      next_st.harvester_off = 1'b0;
    end
    // battery-to-system switch mode
    if (st.chg_s2) begin
      next_st.fet = htr_pkg::HTR_FET_CHARGER;
    end else if (!harvest_interact_en) begin
      next_st.fet = htr_pkg::HTR_FET_DIRECT;
    end else if (inhibit_cond && thermal_inhibit_ctl) begin
      next_st.fet = htr_pkg::HTR_FET_IDEAL;
    end else begin
      next_st.fet = switch_decode(switch_mode);
    end
    // threshold follows the accepted zone every cycle
    next_st.thresh = thresh_mv;
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      st <= '0;
      st.harvest_config <= `HTR_RST_HARVEST_CONFIG;
      st.thermal_config <= `HTR_RST_THERMAL_CONFIG;
      st.harvest_ctrl <= `HTR_RST_HARVEST_CTRL;
      st.zone <= 3'(htr_pkg::HTR_ZONE_ROOM);
      st.zone_s1 <= 3'(htr_pkg::HTR_ZONE_ROOM);
      st.zone_s2 <= 3'(htr_pkg::HTR_ZONE_ROOM);
      st.zone_prev <= 3'(htr_pkg::HTR_ZONE_ROOM);
      st.fet <= htr_pkg::HTR_FET_DIRECT;
      st.thresh <= `HTR_BASE_MV;
    end else begin
      st <= next_st;
    end
  end

  always_comb begin
    o_rdata = st.rdata;
    o_harvester_off_output = st.harvester_off;
    o_fet_mode = st.fet;
    o_thresh_mv = st.thresh;
  end

endmodule // htr_top

/* File: include/htr_cfg.svh */
// offsets, field positions, reset values and widths for the harvester thermal block
`ifndef HTR_CFG_SVH
`define HTR_CFG_SVH

`define HTR_ADDR_W 8
`define HTR_DATA_W 8

`define HTR_OFF_HARVEST_CONFIG 8'h18
`define HTR_OFF_THERMAL_CONFIG 8'h19
`define HTR_OFF_HARVEST_CTRL 8'h1d
`define HTR_OFF_STATUS 8'h1e
`define HTR_OFF_THRESH_LO 8'h1f
`define HTR_OFF_THRESH_HI 8'h20

`define HTR_RST_HARVEST_CONFIG 8'h00
`define HTR_RST_THERMAL_CONFIG 7'h00
`define HTR_RST_HARVEST_CTRL 3'h0

`define HTR_SWITCH_MODE_HI 7
`define HTR_SWITCH_MODE_LO 6
`define HTR_RECHARGE_HI 5
`define HTR_RECHARGE_LO 4
`define HTR_BASE_HI 3
`define HTR_BASE_LO 0

`define HTR_INHIBIT_CTL_BIT 6
`define HTR_WARM_HI 5
`define HTR_WARM_LO 4
`define HTR_ROOM_HI 3
`define HTR_ROOM_LO 2
`define HTR_COOL_HI 1
`define HTR_COOL_LO 0

`define HTR_INTERACT_EN_BIT 0
`define HTR_MON_SEL_HI 2
`define HTR_MON_SEL_LO 1

`define HTR_THRESH_W 13
`define HTR_BASE_MV 13'h0fd2
`define HTR_STEP_MV 13'h0032
`define HTR_BASE_MAX_CODE 4'hb
`define HTR_MON_SEL_OFF 2'h0

`endif

/* File: include/htr_pkg.sv */
// types shared by the harvester thermal block
package htr_pkg;

  typedef enum logic [2:0] {
    HTR_ZONE_COLD,
    HTR_ZONE_COOL,
    HTR_ZONE_ROOM,
    HTR_ZONE_WARM,
    HTR_ZONE_HOT
  } htr_zone_t;

  typedef enum logic [1:0] {
    HTR_FET_DIRECT,
    HTR_FET_AUTO,
    HTR_FET_IDEAL,
    HTR_FET_CHARGER
  } htr_fet_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } htr_bus_req_t;

  typedef struct packed {
    logic [7:0] harvest_config;
    logic [6:0] thermal_config;
    logic [2:0] harvest_ctrl;
    logic chg_s1;
    logic chg_s2;
    logic inh_s1;
    logic inh_s2;
    logic [2:0] zone_s1;
    logic [2:0] zone_s2;
    logic [2:0] zone_prev;
    logic [2:0] zone;
    logic harvester_off;
    htr_fet_t fet;
    logic [12:0] thresh;
    logic [7:0] rdata;
  } htr_state_t;

endpackage

/* File: core/htr_thresh.sv */
// effective harvester regulation threshold from base code and zone reduction
`timescale 1ns/1ps
`include "htr_cfg.svh"

module htr_thresh (
  input wire logic [3:0] i_base_code,
  input wire logic [6:0] i_thermal_config,
  input wire logic [2:0] i_zone,
  output logic [12:0] o_thresh_mv,
  output logic o_base_reserved
);

  logic [3:0] base_clamped;
  logic [1:0] red_code;
  logic [12:0] base_mv;

  // 00 takes 150 mV off, 01 100 mV, 10 50 mV, 11 nothing
  function automatic logic [12:0] reduction_mv(input logic [1:0] code);
    reduction_mv = 13'(2'h3 - code) * `HTR_STEP_MV;
  endfunction

  always_comb begin
    // reserved codes hold the top legal level
    o_base_reserved = i_base_code > `HTR_BASE_MAX_CODE;
    base_clamped = o_base_reserved ? `HTR_BASE_MAX_CODE : i_base_code;
    base_mv = `HTR_BASE_MV + 13'(base_clamped) * `HTR_STEP_MV;
    red_code = 2'h3;
    unique case (i_zone)
      3'(htr_pkg::HTR_ZONE_WARM): red_code = i_thermal_config[`HTR_WARM_HI:`HTR_WARM_LO];
      3'(htr_pkg::HTR_ZONE_ROOM): red_code = i_thermal_config[`HTR_ROOM_HI:`HTR_ROOM_LO];
      3'(htr_pkg::HTR_ZONE_COOL): red_code = i_thermal_config[`HTR_COOL_HI:`HTR_COOL_LO];
      default: red_code = 2'h3;
    endcase
    o_thresh_mv = base_mv - reduction_mv(red_code);
  end

endmodule // htr_thresh

/* File: bench/htr_chk_asserts.sv */
// port checker for the harvester thermal block
`timescale 1ns/1ps
module htr_chk (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic i_charger_input,
  input wire logic i_zone_inhibit,
  input wire logic [2:0] i_zone,
  input wire logic [7:0] o_rdata,
  input wire logic o_harvester_off_output,
  input wire logic [1:0] o_fet_mode,
  input wire logic [12:0] o_thresh_mv
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  property p_rd_idle; !$past(i_rd) |-> o_rdata == 8'h00; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
  property p_wr_rd;
    (i_wr && i_addr == 8'h19) ##1 (i_rd && i_addr == 8'h19) |=> o_rdata == ($past(i_wdata, 2) & 8'h7f);
  endproperty
  a_wr_rd: assert property (p_wr_rd) else $error("config readback");
  property p_unmapped; i_rd && i_addr == 8'h21 |=> o_rdata == 8'h00; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read");
  property p_chg; i_charger_input [*4] |-> o_fet_mode == 2'h3; endproperty
  a_chg: assert property (p_chg) else $error("charger mode");
  property p_nochg; !i_charger_input [*4] |-> o_fet_mode != 2'h3; endproperty
  a_nochg: assert property (p_nochg) else $error("charger mode stuck");
  property p_nocond; (!i_charger_input && !i_zone_inhibit) [*4] |-> !o_harvester_off_output;
  endproperty
  a_nocond: assert property (p_nocond) else $error("harvester off without cause");
  property p_grid;
    o_thresh_mv % 13'd50 == 13'd0 && o_thresh_mv >= 13'd3900 && o_thresh_mv <= 13'd4600;
  endproperty
  a_grid: assert property (p_grid) else $error("threshold off grid");
  property p_hold; (!i_wr && $stable(i_zone)) [*7] |-> $stable(o_thresh_mv); endproperty
  a_hold: assert property (p_hold) else $error("threshold moved");
  property p_rst;
    $fell(i_rst) |-> o_thresh_mv == 13'd4050 && o_fet_mode == 2'h0 && !o_harvester_off_output;
  endproperty
  a_rst: assert property (p_rst) else $error("reset outputs");
  c_off: cover property (o_harvester_off_output && o_fet_mode == 2'h1);
  c_ideal: cover property (o_fet_mode == 2'h2);
  c_chg: cover property (o_fet_mode == 2'h3);
endmodule // htr_chk

/* File: bench/htr_mon.sv */
// thermistor zone monitor and charger-detect model
`timescale 1ns/1ps
module htr_mon (
  input wire logic i_ref_clk,
  input wire logic [2:0] i_zone_cmd,
  input wire logic i_chg_cmd,
  output logic [2:0] o_zone,
  output logic o_zone_inhibit,
  output logic o_charger_input
);
  // cold and hot zones inhibit harvesting
  always_ff @(posedge i_ref_clk) begin
    o_zone <= i_zone_cmd;
    o_zone_inhibit <= (i_zone_cmd == 3'h0) || (i_zone_cmd == 3'h4);
    o_charger_input <= i_chg_cmd;
  end
endmodule // htr_mon

/* File: bench/harvester_thermal_reg_control_test.sv */
// self-checking bench for the harvester thermal block
`timescale 1ns/1ps
module harvester_thermal_reg_control_test;
  logic i_ref_clk = 1'b0;
  logic i_rst = 1'b1;
  logic [7:0] i_addr = 8'h00, i_wdata = 8'h00;
  logic i_wr = 1'b0, i_rd = 1'b0, chg_cmd = 1'b0;
  logic [2:0] zone_cmd = 3'h2;
  logic i_charger_input, i_zone_inhibit, o_harvester_off_output;
  logic [2:0] i_zone;
  logic [7:0] o_rdata;
  logic [1:0] o_fet_mode;
  logic [12:0] o_thresh_mv;
  int err_count = 0, num_checks = 0;
  htr_top htr_top_i (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .i_charger_input(i_charger_input), .i_zone_inhibit(i_zone_inhibit),
    .i_zone(i_zone), .o_rdata(o_rdata), .o_harvester_off_output(o_harvester_off_output),
    .o_fet_mode(o_fet_mode), .o_thresh_mv(o_thresh_mv));
  htr_mon htr_mon_i (.i_ref_clk(i_ref_clk), .i_zone_cmd(zone_cmd), .i_chg_cmd(chg_cmd),
    .o_zone(i_zone), .o_zone_inhibit(i_zone_inhibit), .o_charger_input(i_charger_input));
  initial begin
    forever #12.5 i_ref_clk = ~i_ref_clk;
  end
  task automatic check(input logic [12:0] seen, input logic [12:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_ref_clk);
    i_wr <= 1'b0;
    @(posedge i_ref_clk);
  endtask
  task automatic wr_rd(input logic [7:0] a, input logic [7:0] d, input logic [7:0] e);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_ref_clk);
    i_wr <= 1'b0;
    i_rd <= 1'b1;
    @(posedge i_ref_clk);
    i_rd <= 1'b0;
    #1 check({5'h00, o_rdata}, {5'h00, e});
    @(posedge i_ref_clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_ref_clk);
    i_rd <= 1'b0;
    #1 check({5'h00, o_rdata}, {5'h00, e});
    @(posedge i_ref_clk);
  endtask
  task automatic expect3(input logic off, input logic [1:0] fet, input logic [12:0] thr);
    repeat (8) @(posedge i_ref_clk);
    #1 check({12'h000, o_harvester_off_output}, {12'h000, off});
    check({11'h000, o_fet_mode}, {11'h000, fet});
    check(o_thresh_mv, thr);
    @(posedge i_ref_clk);
  endtask
  task automatic t_zones;
    logic [12:0] red[4] = '{13'd150, 13'd100, 13'd50, 13'd0};
    wr(8'h18, 8'h02);
    for (int z = 1; z < 4; z++) begin
      zone_cmd <= 3'(z);
      for (int c = 0; c < 4; c++) begin
        wr(8'h19, 8'(c << (2 * z - 2)));
        expect3(1'b0, 2'h0, 13'd4150 - red[c]);
      end
    end
    zone_cmd <= 3'h4;
    expect3(1'b0, 2'h0, 13'd4150);
    wr(8'h18, 8'h0b);
    expect3(1'b0, 2'h0, 13'd4600);
    wr(8'h18, 8'h0f);
    expect3(1'b0, 2'h0, 13'd4600);
  endtask
  task automatic t_inhibit;
    logic [1:0] fet_exp[4] = '{2'h0, 2'h1, 2'h2, 2'h2};
    wr(8'h19, 8'h3f);
    wr(8'h1d, 8'h01);
    for (int m = 0; m < 4; m++) begin
      wr(8'h18, 8'(m << 6));
      expect3(1'b0, fet_exp[m], 13'd4050);
    end
    wr(8'h18, 8'h40);
    wr(8'h1d, 8'h03);
    expect3(1'b1, 2'h1, 13'd4050);
    rd(8'h1e, 8'h6c);
    rd(8'h1f, 8'hd2);
    rd(8'h20, 8'h0f);
    rd(8'h1d, 8'h03);
    rd(8'h18, 8'h40);
    wr_rd(8'h19, 8'hff, 8'h7f);
    expect3(1'b0, 2'h2, 13'd4050);
    zone_cmd <= 3'h2;
    expect3(1'b0, 2'h1, 13'd4050);
    chg_cmd <= 1'b1;
    expect3(1'b1, 2'h3, 13'd4050);
    rd(8'h21, 8'h00);
    wr(8'h1d, 8'h00);
    expect3(1'b0, 2'h3, 13'd4050);
  endtask
  task automatic print_verdict;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    #1 check(o_thresh_mv, 13'd4050);
    @(posedge i_ref_clk);
    rd(8'h19, 8'h00);
    t_zones();
    t_inhibit();
    print_verdict();
  end
endmodule // harvester_thermal_reg_control_test
bind htr_top htr_chk htr_chk_i (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_addr(i_addr),
  .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .i_charger_input(i_charger_input),
  .i_zone_inhibit(i_zone_inhibit), .i_zone(i_zone), .o_rdata(o_rdata),
  .o_harvester_off_output(o_harvester_off_output), .o_fet_mode(o_fet_mode),
  .o_thresh_mv(o_thresh_mv));
